//--- hw/reset_standby_interrupt_ctrl.sv
// System control block: reset sequence, standby, interrupts, timer and port/mode registers.
`timescale 1ns/1ps
`include "rsi_ctrl_regs.svh"

module reset_standby_interrupt_ctrl #(
  parameter int OSC_WAIT = `OSC_WAIT_PULSES
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // Reset pin and oscillator input
  input wire logic resetPin_n,
  input wire logic oscillatorInput,
  // Core transfer port
  input wire logic ioStrobe,
  input wire rsi_ctrl_pkg::io_req_t ioReq,
  output logic [7:0] rdData_r,
  output logic rdValid_r,
  // Core control strobes
  input wire logic enableIntStrobe,
  input wire logic disableIntStrobe,
  input wire logic haltStrobe,
  input wire logic stopStrobe,
  input wire logic callPush,
  input wire logic returnPop,
  input wire logic intAck,
  // Core sequencing
  output logic cpuReset_r,
  output logic cpuClkEn_r,
  output logic pcLoad_r,
  output logic [11:0] pcLoadAddr_r,
  output logic intReq_r,
  output logic [1:0] stackLevel_r,
  // Port pins
  input wire logic [3:0] pullupIn,
  input wire logic [3:0] ioAIn,
  input wire logic [3:0] analogIn,
  input wire logic [3:0] ioBIn,
  input wire logic [3:0] ioCIn,
  output logic [3:0] invertedOutputPort_r,
  output rsi_ctrl_pkg::io_pins_t ioPins_r,
  // Converter
  input wire logic comparisonResult,
  input wire logic convDone,
  input wire logic [9:0] convResult,
  output logic [3:0] convPinSelect_r,
  output logic [3:0] convChannel_r,
  output logic [7:0] convControl_r,
  output logic [7:0] convHigh_r
);

  // ----------------------------------------------------------------
  // Instruction cycle timing
  // ----------------------------------------------------------------
  rsi_ctrl_pkg::sys_state_t state_r;
  rsi_ctrl_pkg::sys_state_t state_nxt;
  logic [1:0] cycCnt_r;
  logic [1:0] lowCnt_r;
  logic [15:0] oscCnt_r;
  logic [5:0] wakeCnt_r;
  logic oscPrev_r;
  wire cycTick = (cycCnt_r == `CYCLE_DIV);
  wire running = (state_r == rsi_ctrl_pkg::ST_RUN);
  wire inStop = (state_r == rsi_ctrl_pkg::ST_STOP) || (state_r == rsi_ctrl_pkg::ST_WAKE);
  wire inHold = (state_r == rsi_ctrl_pkg::ST_HOLD) || (state_r == rsi_ctrl_pkg::ST_ENTER);
  wire sysTick = cycTick && running;
  wire mainTick = cycTick && !inStop;
  wire oscRise = oscillatorInput && !oscPrev_r;
  wire oscDone = (oscCnt_r == 16'(OSC_WAIT - 1)) && oscRise;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cycCnt_r <= 2'h0;
    else
      cycCnt_r <= cycTick ? 2'h0 : cycCnt_r + 2'h1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] invLatch_r;
  logic [3:0] ioALatch_r;
  logic [3:0] ioBLatch_r;
  logic [3:0] ioCLatch_r;
  logic [3:0] dirA_r;
  logic [3:0] ioBOe_r;
  logic [3:0] ioCOe_r;
  logic [3:0] pinSel_r;
  logic [7:0] convCtrl_r;
  logic [7:0] convHigh_r_q;
  logic [7:0] tmrCount_r;
  logic [7:0] tmrReload_r;
  logic [3:0] tmrCtrl_r;
  logic [3:0] intMask_r;
  logic [14:0] divider_r;
  logic [3:0] pullPrev_r;
  logic pin0Flag_r;
  logic pin1Flag_r;
  logic tmrFlag_r;
  logic masterEnable_r;

  // ----------------------------------------------------------------
  // Transfer decode
  // ----------------------------------------------------------------
  wire rsi_ctrl_pkg::io_op_t op = ioReq.op;
  wire [3:0] ptr = ioReq.lowPtr;
  wire [3:0] wrNib = ioReq.data[3:0];
  wire [7:0] wrByte = ioReq.data;
  wire isOut = ioStrobe && sysTick && (op == rsi_ctrl_pkg::OP_OUT);
  wire isLogic = ioStrobe && sysTick && ((op == rsi_ctrl_pkg::OP_AND_PORT) || (op == rsi_ctrl_pkg::OP_OR_PORT));
  wire isRead = ioStrobe && sysTick && ((op == rsi_ctrl_pkg::OP_IN) || (op == rsi_ctrl_pkg::OP_TEST_BIT));
  wire isOutl = ioStrobe && sysTick && (op == rsi_ctrl_pkg::OP_OUT_LATCH);
  wire isInl = ioStrobe && sysTick && (op == rsi_ctrl_pkg::OP_IN_LATCH);
  wire logicPort = (ptr == `PTR_INV_OUT) || (ptr == `PTR_IO_A) || (ptr == `PTR_IO_B) || (ptr == `PTR_IO_C);
  wire [3:0] logicMask = (op == rsi_ctrl_pkg::OP_AND_PORT) ? wrNib : ~wrNib;
  wire [3:0] logicOr = (op == rsi_ctrl_pkg::OP_OR_PORT) ? wrNib : 4'h0;
  wire wrInv = (isOut && ptr == `PTR_INV_OUT) || isOutl || (isLogic && ptr == `PTR_INV_OUT);
  wire wrIoA = (isOut || isLogic) && ptr == `PTR_IO_A;
  wire wrIoB = (isOut || isLogic) && ptr == `PTR_IO_B;
  wire wrIoC = (isOut || isLogic) && ptr == `PTR_IO_C;
  wire wrPinSel = isOut && ptr == `PTR_ANALOG;
  wire wrConvCtrl = isOut && ptr == `PTR_CONV_CTRL;
  wire wrConvHigh = isOut && ptr == `PTR_CONV_HIGH;
  wire wrCount = isOut && ptr == `PTR_TMR_COUNT;
  wire wrReload = isOut && ptr == `PTR_TMR_RELOAD;
  wire wrTmrCtrl = isOut && ptr == `PTR_TMR_CTRL;
  wire wrMask = isOut && ptr == `PTR_INT_MASK;
  wire wrDir = isOut && ptr == `PTR_DIR_A;
  wire [3:0] newInv = isLogic ? ((invLatch_r & logicMask) | logicOr) : wrNib;
  wire [3:0] newIoA = isLogic ? ((ioALatch_r & logicMask) | logicOr) : wrNib;
  wire [3:0] newIoB = isLogic ? ((ioBLatch_r & logicMask) | logicOr) : wrNib;
  wire [3:0] newIoC = isLogic ? ((ioCLatch_r & logicMask) | logicOr) : wrNib;

  // Output bits read back their latch, input bits read the pin; converter pins read as zero.
  wire [3:0] ioARead = (ioALatch_r & dirA_r) | (ioAIn & ~dirA_r);
  wire [3:0] ioBRead = (ioBLatch_r & ioBOe_r) | (ioBIn & ~ioBOe_r);
  wire [3:0] ioCRead = (ioCLatch_r & ioCOe_r) | (ioCIn & ~ioCOe_r);
  // The comparison bit is sampled live and never written, so reads and writes disturb nothing.
  wire [7:0] convCtrlRead = {convCtrl_r[7:5], comparisonResult, convCtrl_r[3:0]};
  logic [7:0] readMux;
  always_comb
  begin
    case (ptr)
      `PTR_PULLUP_IN: readMux = {4'h0, pullupIn};
      `PTR_IO_A: readMux = {4'h0, ioARead};
      `PTR_ANALOG: readMux = {4'h0, analogIn & ~pinSel_r};
      `PTR_IO_B: readMux = {4'h0, ioBRead};
      `PTR_IO_C: readMux = {4'h0, ioCRead};
      `PTR_CONV_CTRL: readMux = convCtrlRead;
      `PTR_CONV_HIGH: readMux = convHigh_r_q;
      `PTR_TMR_COUNT: readMux = tmrCount_r;
      `PTR_TMR_RELOAD: readMux = tmrReload_r;
      `PTR_TMR_CTRL: readMux = {4'h0, tmrCtrl_r};
      `PTR_INT_MASK: readMux = {4'h0, intMask_r};
      `PTR_DIR_A: readMux = {4'h0, dirA_r};
      default: readMux = 8'h00;
    endcase
  end
  wire [7:0] readByte = isInl ? {4'h0, pullupIn} : readMux;
  wire [7:0] readAnswer = (op == rsi_ctrl_pkg::OP_TEST_BIT) ? {7'h00, readMux[ioReq.bitSel]} : readByte;

  // ----------------------------------------------------------------
  // Timer and divider
  // ----------------------------------------------------------------
  wire [14:0] divNext = divider_r + 15'h0001;
  wire div7Tick = mainTick && (divNext[`DIV_TAP_7:0] == 7'h00);
  wire div15Tick = mainTick && (divNext == 15'h0000);
  wire pin0Fall = pullPrev_r[0] && !pullupIn[0];
  wire pin1Fall = pullPrev_r[1] && !pullupIn[1];
  logic countTick;
  always_comb
  begin
    case (tmrCtrl_r[1:0])
      `TC_SRC_SYS: countTick = mainTick;
      `TC_SRC_DIV7: countTick = div7Tick;
      `TC_SRC_DIV15: countTick = div15Tick;
      `TC_SRC_EXT: countTick = pin1Fall;
      default: countTick = 1'b0;
    endcase
  end
  wire tmrStep = tmrCtrl_r[`TC_START_BIT] && countTick;
  wire tmrOverflow = tmrStep && (tmrCount_r == 8'hFF);

  // ----------------------------------------------------------------
  // Interrupt requests and priority
  // ----------------------------------------------------------------
  wire [2:0] flags = {tmrFlag_r, pin1Flag_r, pin0Flag_r};
  wire [2:0] pending = flags & intMask_r[2:0] & {3{masterEnable_r}};
  wire [2:0] grant = pending[0] ? 3'h1 : (pending[1] ? 3'h2 : (pending[2] ? 3'h4 : 3'h0));
  wire [5:0] vecStep = grant[0] ? `VEC_STEP_PIN0 : (grant[1] ? `VEC_STEP_PIN1 : `VEC_STEP_TMR);
  wire take = intAck && intReq_r && running;
  wire wake = !pullupIn[2] || !pullupIn[3] || (!pullupIn[0] && intMask_r[0])
              || (!pullupIn[1] && intMask_r[1]) || (tmrFlag_r && intMask_r[2]);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire pinLow = !resetPin_n;
  wire lowDone = pinLow && cycTick && (lowCnt_r == `RESET_LOW_CYCLES - 2'h1);
  always_comb
  begin
    case (state_r)
      rsi_ctrl_pkg::ST_ENTER: state_nxt = rsi_ctrl_pkg::ST_HOLD;
      rsi_ctrl_pkg::ST_HOLD: state_nxt = (!pinLow && oscDone) ? rsi_ctrl_pkg::ST_RUN : state_r;
      rsi_ctrl_pkg::ST_RUN:
        state_nxt = stopStrobe && cycTick ? rsi_ctrl_pkg::ST_STOP :
                    (haltStrobe && cycTick ? rsi_ctrl_pkg::ST_HALT : state_r);
      rsi_ctrl_pkg::ST_HALT: state_nxt = wake ? rsi_ctrl_pkg::ST_RUN : state_r;
      rsi_ctrl_pkg::ST_STOP: state_nxt = wake ? rsi_ctrl_pkg::ST_WAKE : state_r;
      rsi_ctrl_pkg::ST_WAKE: state_nxt = (wakeCnt_r == `STOP_WAKE_CYCLES) ? rsi_ctrl_pkg::ST_RUN : state_r;
      default: state_nxt = rsi_ctrl_pkg::ST_HOLD;
    endcase
  end
  // Reset request from the pin overrides every state, standby included.
  wire enterReset = lowDone && !inHold;
  wire clr = inHold;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= rsi_ctrl_pkg::ST_HOLD;
      lowCnt_r <= 2'h0;
      oscCnt_r <= 16'h0000;
      wakeCnt_r <= 6'h00;
      oscPrev_r <= 1'b0;
    end
    else
    begin
      state_r <= enterReset ? rsi_ctrl_pkg::ST_ENTER : state_nxt;
      oscPrev_r <= oscillatorInput;
      if (!pinLow)
        lowCnt_r <= 2'h0;
      else if (cycTick && lowCnt_r != `RESET_LOW_CYCLES)
        lowCnt_r <= lowCnt_r + 2'h1;
      if (!inHold || pinLow)
        oscCnt_r <= 16'h0000;
      else if (oscRise)
        oscCnt_r <= oscCnt_r + 16'h0001;
      wakeCnt_r <= (state_r == rsi_ctrl_pkg::ST_WAKE) ? wakeCnt_r + 6'h01 : 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Register updates; standby takes no writes, but in halt the divider and timer still count, in stop only the timer on pin 1 edges
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      invLatch_r <= `NIB_RESET;
      ioALatch_r <= `NIB_RESET;
      ioBLatch_r <= `NIB_RESET;
      ioCLatch_r <= `NIB_RESET;
      dirA_r <= `NIB_RESET;
      ioBOe_r <= `NIB_RESET;
      ioCOe_r <= `NIB_RESET;
      pinSel_r <= `NIB_RESET;
      tmrCtrl_r <= `NIB_RESET;
      intMask_r <= `NIB_RESET;
    end
    else if (clr)
    begin
      invLatch_r <= `NIB_RESET;
      ioALatch_r <= `NIB_RESET;
      ioBLatch_r <= `NIB_RESET;
      ioCLatch_r <= `NIB_RESET;
      dirA_r <= `NIB_RESET;
      ioBOe_r <= `NIB_RESET;
      ioCOe_r <= `NIB_RESET;
      pinSel_r <= `NIB_RESET;
      tmrCtrl_r <= `NIB_RESET;
      intMask_r <= `NIB_RESET;
    end
    else
    begin
      if (wrInv) invLatch_r <= newInv;
      if (wrIoA) ioALatch_r <= newIoA;
      if (wrIoB) ioBLatch_r <= newIoB;
      if (wrIoC) ioCLatch_r <= newIoC;
      if (wrIoB && isOut) ioBOe_r <= 4'hF;
      if (wrIoC && isOut) ioCOe_r <= 4'hF;
      if (wrDir) dirA_r <= wrNib;
      if (wrPinSel) pinSel_r <= wrNib;
      if (wrTmrCtrl) tmrCtrl_r <= wrNib & `TC_WRITE_MASK;
      if (wrMask) intMask_r <= wrNib & `IM_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      convCtrl_r <= `BYTE_RESET;
      convHigh_r_q <= `BYTE_RESET;
      tmrCount_r <= `BYTE_RESET;
      tmrReload_r <= `BYTE_RESET;
      divider_r <= 15'h0000;
    end
    else if (clr)
    begin
      convCtrl_r <= `BYTE_RESET;
      convHigh_r_q <= `BYTE_RESET;
      tmrCount_r <= `BYTE_RESET;
      tmrReload_r <= `BYTE_RESET;
      divider_r <= 15'h0000;
    end
    else
    begin
      if (wrConvCtrl)
        convCtrl_r <= wrByte & ~(8'h01 << `CC_CMP_BIT);
      else if (convDone)
      begin
        convCtrl_r[`CC_ENABLE_BIT] <= 1'b0;
        convCtrl_r[`CC_START_BIT] <= 1'b0;
        if (!convCtrl_r[`CC_MODE_BIT])
          convCtrl_r[7:6] <= convResult[1:0];
      end
      if (wrConvHigh)
        convHigh_r_q <= wrByte;
      else if (convDone && !convCtrl_r[`CC_MODE_BIT])
        convHigh_r_q <= convResult[9:2];
      if (mainTick)
        divider_r <= divNext;
      if (wrCount || tmrOverflow)
        tmrCount_r <= tmrReload_r;
      else if (tmrStep)
        tmrCount_r <= tmrCount_r + 8'h01;
      if (wrReload)
        tmrReload_r <= wrByte;
    end
  end

  // ----------------------------------------------------------------
  // Request flags, master enable and return stack level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin0Flag_r <= 1'b0;
      pin1Flag_r <= 1'b0;
      tmrFlag_r <= 1'b0;
      masterEnable_r <= 1'b0;
      stackLevel_r <= `STACK_LEVEL_RESET;
      pullPrev_r <= 4'hF;
    end
    else if (clr)
    begin
      pin0Flag_r <= 1'b0;
      pin1Flag_r <= 1'b0;
      tmrFlag_r <= 1'b0;
      masterEnable_r <= 1'b0;
      stackLevel_r <= `STACK_LEVEL_RESET;
      pullPrev_r <= 4'hF;
    end
    else
    begin
      pullPrev_r <= pullupIn;
      // A new edge in the cycle of service wins over the clear.
      pin0Flag_r <= pin0Fall || (pin0Flag_r && !(take && grant[0]));
      pin1Flag_r <= pin1Fall || (pin1Flag_r && !(take && grant[1]));
      tmrFlag_r <= tmrOverflow || (tmrFlag_r && !(take && grant[2]));
      if (enableIntStrobe && sysTick)
        masterEnable_r <= 1'b1;
      else if (disableIntStrobe && sysTick)
        masterEnable_r <= 1'b0;
      if (take || (callPush && sysTick))
        stackLevel_r <= stackLevel_r + 2'h1;
      else if (returnPop && sysTick)
        stackLevel_r <= stackLevel_r - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
      cpuReset_r <= 1'b1;
      cpuClkEn_r <= 1'b0;
      pcLoad_r <= 1'b0;
      pcLoadAddr_r <= `START_ADDR;
      intReq_r <= 1'b0;
      invertedOutputPort_r <= 4'hF;
      ioPins_r <= '0;
      convPinSelect_r <= 4'h0;
      convChannel_r <= 4'h0;
      convControl_r <= 8'h00;
      convHigh_r <= 8'h00;
    end
    else
    begin
      rdValid_r <= isRead || isInl;
      if (isRead || isInl)
        rdData_r <= readAnswer;
      cpuReset_r <= inHold;
      cpuClkEn_r <= (state_nxt == rsi_ctrl_pkg::ST_RUN) && !enterReset && (cycCnt_r == `CYCLE_DIV - 2'h1);
      pcLoad_r <= (state_r == rsi_ctrl_pkg::ST_HOLD && state_nxt == rsi_ctrl_pkg::ST_RUN) || take;
      pcLoadAddr_r <= take ? {`VEC_PAGE, vecStep} : `START_ADDR;
      intReq_r <= (|grant) && running && !take;
      invertedOutputPort_r <= ~invLatch_r;
      ioPins_r <= '{ioAOut: ioALatch_r, ioAOe: dirA_r, ioBOut: ioBLatch_r, ioBOe: ioBOe_r,
                    ioCOut: ioCLatch_r, ioCOe: ioCOe_r};
      convPinSelect_r <= pinSel_r;
      convChannel_r <= pinSel_r & (4'h1 << convCtrl_r[1:0]);
      convControl_r <= convCtrlRead;
      convHigh_r <= convHigh_r_q;
    end
  end

endmodule // reset_standby_interrupt_ctrl

//--- hw/rsi_ctrl_pkg.sv
// Types shared by the system control block and its users.
package rsi_ctrl_pkg;

  typedef enum logic [2:0] {
    OP_OUT = 3'h0,
    OP_OUT_LATCH = 3'h1,
    OP_IN = 3'h2,
    OP_IN_LATCH = 3'h3,
    OP_TEST_BIT = 3'h4,
    OP_AND_PORT = 3'h5,
    OP_OR_PORT = 3'h6
  } io_op_t;

  typedef struct packed {
    io_op_t op;
    logic [3:0] lowPtr;
    logic [7:0] data;
    logic [1:0] bitSel;
  } io_req_t;

  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_RUN = 6'h02,
    ST_HALT = 6'h04,
    ST_STOP = 6'h08,
    ST_WAKE = 6'h10,
    ST_ENTER = 6'h20
  } sys_state_t;

  typedef struct packed {
    logic [3:0] ioAOut;
    logic [3:0] ioAOe;
    logic [3:0] ioBOut;
    logic [3:0] ioBOe;
    logic [3:0] ioCOut;
    logic [3:0] ioCOe;
  } io_pins_t;

endpackage

//--- hw/rsi_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the system control block.
// Functional notes
// - Reset pin low two instruction cycles enters reset
// - Release after 2^15 oscillator pulses, start page 0
// - Reset makes I/O pins inputs, clears mode registers
// - Reset clears inverted latch, inverted pins go high
// - Reset clears request flags and master enable
// - Reset zeroes counters, latches; stack level zero
// - Comparison result bit read-only, no side effects
// - Halt stops system clock, divider keeps running
// - Stop halts everything but external-event timer
// - Standby keeps flags, latches and mode registers
// - Five standby release events, two nonmaskable pins
// - Stop wake-up takes longer than halt wake-up
// - Pin falling edges and overflow set request flags
// - Fixed priority vectors to page 2 steps 0,2,4
// - Enable sets, disable clears master enable flag
// - Mask bits gate each interrupt source separately
// - Timer: 8-bit count, reload, 15-bit divider, control
// - Control low bits select count clock source
// - Low pointer selects register; only listed transfers
// - Output latches drive their pins one clock later, the inverted port complemented
// - Pin select plus channel picks one converter input
// - Interrupt service consumes one return stack level
// - Mask bits also gate standby release sources
`ifndef RSI_CTRL_REGS_SVH
`define RSI_CTRL_REGS_SVH

`define PTR_INV_OUT 4'h0
`define PTR_PULLUP_IN 4'h1
`define PTR_IO_A 4'h2
`define PTR_ANALOG 4'h3
`define PTR_IO_B 4'h4
`define PTR_IO_C 4'h5
`define PTR_CONV_CTRL 4'h8
`define PTR_CONV_HIGH 4'h9
`define PTR_TMR_COUNT 4'hA
`define PTR_TMR_RELOAD 4'hB
`define PTR_TMR_CTRL 4'hC
`define PTR_INT_MASK 4'hE
`define PTR_DIR_A 4'hF

`define NIB_RESET 4'h0
`define BYTE_RESET 8'h00

`define CC_CMP_BIT 4
`define CC_ENABLE_BIT 5
`define CC_START_BIT 3
`define CC_MODE_BIT 2
`define TC_START_BIT 3
`define TC_SRC_SYS 2'h0
`define TC_SRC_DIV7 2'h1
`define TC_SRC_DIV15 2'h2
`define TC_SRC_EXT 2'h3
`define TC_WRITE_MASK 4'hB
`define IM_WRITE_MASK 4'h7

`define VEC_PAGE 6'h02
`define VEC_STEP_PIN0 6'h00
`define VEC_STEP_PIN1 6'h02
`define VEC_STEP_TMR 6'h04
`define START_ADDR 12'h000

`define RESET_LOW_CYCLES 2'h2
`define OSC_WAIT_PULSES 32768
`define CYCLE_DIV 2'h3
`define STOP_WAKE_CYCLES 6'h20
`define DIV_TAP_7 6
`define DIV_TAP_15 14
`define STACK_LEVEL_RESET 2'h0

`endif

//--- tb/reset_standby_interrupt_ctrl_asserts.sv
// Port checker for the system control block.
`timescale 1ns/1ps
module reset_standby_interrupt_ctrl_asserts (
  // Clock and reset
  input logic sys_clk,
  input logic reset,
  // Inputs watched
  input logic resetPin_n,
  input logic ioStrobe,
  input rsi_ctrl_pkg::io_req_t ioReq,
  input logic intAck,
  // Outputs watched
  input logic rdValid_r,
  input logic cpuReset_r,
  input logic cpuClkEn_r,
  input logic pcLoad_r,
  input logic [11:0] pcLoadAddr_r,
  input logic intReq_r,
  input logic [1:0] stackLevel_r,
  input logic [3:0] invertedOutputPort_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire intTaken = intAck && intReq_r && !cpuReset_r;
  vector_page_a: assert property (intTaken |=> pcLoad_r && pcLoadAddr_r[11:6] == 6'h02)
    else $error("interrupt take did not load a page 2 vector");
  start_addr_a: assert property (pcLoad_r && cpuReset_r |-> pcLoadAddr_r == 12'h000)
    else $error("start address after hold is not zero");
  stack_push_a: assert property (intTaken |=> stackLevel_r == $past(stackLevel_r) + 2'h1)
    else $error("interrupt take did not use one stack level");
  served_clear_a: assert property (intTaken |=> !intReq_r)
    else $error("request still raised after take");
  hold_state_a: assert property (cpuReset_r && $past(cpuReset_r) |-> invertedOutputPort_r == 4'hF
    && stackLevel_r == 2'h0)
    else $error("hold state not cleared");
  tick_space_a: assert property (cpuClkEn_r |=> !cpuClkEn_r [*3])
    else $error("instruction ticks closer than four clocks");
  pin_entry_a: assert property ($rose(cpuReset_r) |-> !$past(resetPin_n) && !$past(resetPin_n, 4))
    else $error("hold entered without a held low reset pin");
  release_order_a: assert property ($fell(cpuReset_r) |-> $past(pcLoad_r))
    else $error("hold left without start address load");
  read_answer_a: assert property (rdValid_r |-> ($past(ioStrobe) || $past(ioStrobe, 2)) && ($past(ioReq.op)
    inside {rsi_ctrl_pkg::OP_IN, rsi_ctrl_pkg::OP_IN_LATCH, rsi_ctrl_pkg::OP_TEST_BIT}))
    else $error("read answer without a read request");
  cover property (intTaken);
  cover property ($fell(cpuReset_r));
  cover property (rdValid_r);
endmodule // reset_standby_interrupt_ctrl_asserts

bind reset_standby_interrupt_ctrl reset_standby_interrupt_ctrl_asserts i_chk (.sys_clk, .reset, .resetPin_n,
  .ioStrobe, .ioReq, .intAck, .rdValid_r, .cpuReset_r, .cpuClkEn_r, .pcLoad_r, .pcLoadAddr_r, .intReq_r,
  .stackLevel_r, .invertedOutputPort_r);

//--- tb/reset_standby_interrupt_ctrl_bench.sv
// Self-checking bench for the system control block.
`timescale 1ns/1ps
module reset_standby_interrupt_ctrl_bench;
  logic sys_clk = 1'b0, reset = 1'b1, rstReq = 1'b0, ioStrobe = 1'b0, intAck = 1'b0;
  logic resetPin_n, oscillatorInput, rdValid_r, cpuReset_r, cpuClkEn_r, pcLoad_r, intReq_r;
  logic [5:0] ctl = 6'h00;
  logic [3:0] pullLow = 4'h0, pullupIn, invertedOutputPort_r, convPinSelect_r;
  logic [7:0] d, rd, rdData_r, convHigh_r;
  logic [11:0] vec, pcLoadAddr_r;
  logic [1:0] stackLevel_r;
  logic [31:0] rnd = 32'h20CC;
  logic [7:0] mdl [16];
  logic [3:0] regs [6] = '{4'hA, 4'h9, 4'hB, 4'hC, 4'hE, 4'hF};
  logic [7:0] msk [6] = '{8'h00, 8'hFF, 8'hFF, 8'h0B, 8'h07, 8'h0F};
  logic [11:0] vq [$] = {12'h080, 12'h082, 12'h084};
  rsi_ctrl_pkg::io_req_t ioReq = '0;
  rsi_ctrl_pkg::io_pins_t ioPins_r;
  int bad_count = 0, num_checks = 0, cyc = 0, ticks = 0, nh, ns;

  rsi_pins_model i_pins (.sys_clk, .rstReq, .pullLow, .resetPin_n, .oscillatorInput, .pullupIn);
  reset_standby_interrupt_ctrl #(.OSC_WAIT(8)) i_dut (.sys_clk, .reset, .resetPin_n, .oscillatorInput,
    .ioStrobe, .ioReq, .rdData_r, .rdValid_r, .enableIntStrobe(ctl[0]), .disableIntStrobe(ctl[1]),
    .haltStrobe(ctl[2]), .stopStrobe(ctl[3]), .callPush(ctl[4]), .returnPop(ctl[5]), .intAck,
    .cpuReset_r, .cpuClkEn_r, .pcLoad_r, .pcLoadAddr_r, .intReq_r, .stackLevel_r, .pullupIn,
    .ioAIn(rnd[3:0]), .analogIn(rnd[18:15]), .ioBIn(rnd[22:19]), .ioCIn(rnd[26:23]),
    .invertedOutputPort_r, .ioPins_r, .comparisonResult(rnd[14]), .convDone(1'b0),
    .convResult(rnd[13:4]), .convPinSelect_r, .convChannel_r(), .convControl_r(), .convHigh_r);

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) rnd <= lfsr(rnd);
  always @(posedge sys_clk)
  begin
    cyc++;
    ticks += int'(cpuClkEn_r === 1'b1);
    if (rdValid_r === 1'b1) rd = rdData_r;
    if (pcLoad_r === 1'b1) vec = pcLoadAddr_r;
    if (cyc == 6000)
    begin
      bad_count++;
      results();
    end
  end

  task results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Requests are held across both edges of the tick window; only the tick edge takes them.
  task ins(input logic [5:0] c, input logic s, input rsi_ctrl_pkg::io_op_t op, input logic [3:0] p,
    input logic [7:0] v);
    do @(negedge sys_clk); while (cpuClkEn_r !== 1'b1);
    ctl = c;
    ioStrobe = s;
    ioReq = '{op, p, v, 2'h0};
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    ctl = 6'h00;
    ioStrobe = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task wr(input logic [3:0] p, input logic [7:0] v);
    ins(6'h00, 1'b1, rsi_ctrl_pkg::OP_OUT, p, v);
  endtask

  task rdchk(input logic [3:0] p, input logic [7:0] e);
    rd = 8'hXX;
    ins(6'h00, 1'b1, rsi_ctrl_pkg::OP_IN, p, 8'h00);
    chk(rd, e);
  endtask

  task waitRun();
    int n;
    n = 0;
    vec = 12'hFFF;
    do @(negedge sys_clk); while (cpuReset_r !== 1'b0 && ++n < 500);
    chk(12'(n >= 15 && n < 500), 12'h001);
    chk(vec, 12'h000);
  endtask

  task take(input logic [11:0] e);
    int n;
    n = 0;
    vec = 12'hFFF;
    do @(negedge sys_clk); while (intReq_r !== 1'b1 && ++n < 200);
    intAck = 1'b1;
    @(negedge sys_clk);
    intAck = 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(vec, e);
    chk(stackLevel_r, 2'h1);
  endtask

  task standby(input logic [5:0] c, input logic [3:0] pin, output int n);
    int t;
    ins(c, 1'b0, rsi_ctrl_pkg::OP_IN, 4'h0, 8'h00);
    t = ticks;
    @(negedge sys_clk);
    pullLow = 4'h1;
    repeat (20) @(negedge sys_clk);
    chk(12'(ticks - t), 12'h000);
    pullLow = pin;
    n = 0;
    while (ticks == t && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    pullLow = 4'h0;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    waitRun();
    chk(invertedOutputPort_r, 4'hF);
    chk({ioPins_r.ioAOe, ioPins_r.ioBOe, ioPins_r.ioCOe}, 12'h000);
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    for (int i = 1; i < 6; i++)
    begin
      d = rnd[7:0];
      mdl[regs[i]] = d & msk[i];
      wr(regs[i], d);
      rdchk(regs[i], mdl[regs[i]]);
    end
    chk(ioPins_r.ioAOe, mdl[15][3:0]);
    chk(convHigh_r, mdl[9]);
    wr(4'hC, 8'h00);
    wr(4'hA, 8'h00);
    rdchk(4'hA, mdl[11]);
    ins(6'h00, 1'b1, rsi_ctrl_pkg::OP_AND_PORT, 4'hE, 8'h00);
    rdchk(4'hE, mdl[14]);
    d = rnd[7:0];
    wr(4'h3, d);
    chk(convPinSelect_r, d[3:0]);
    ins(6'h00, 1'b1, rsi_ctrl_pkg::OP_OUT_LATCH, 4'h9, d);
    chk(invertedOutputPort_r, 4'(~d));
    ins(6'h00, 1'b1, rsi_ctrl_pkg::OP_OR_PORT, 4'h0, 8'h01);
    chk(invertedOutputPort_r, 4'(~(d | 8'h01)));
    wr(4'hB, 8'hFE);
    wr(4'hA, 8'h00);
    wr(4'hC, 8'h08);
    wr(4'hE, 8'h07);
    ins(6'h01, 1'b0, rsi_ctrl_pkg::OP_IN, 4'h0, 8'h00);
    @(negedge sys_clk);
    pullLow = 4'h3;
    foreach (vq[i])
    begin
      take(vq[i]);
      ins(6'h20, 1'b0, rsi_ctrl_pkg::OP_IN, 4'h0, 8'h00);
    end
    pullLow = 4'h0;
    wr(4'hC, 8'h00);
    ins(6'h02, 1'b0, rsi_ctrl_pkg::OP_IN, 4'h0, 8'h00);
    @(negedge sys_clk);
    pullLow = 4'h1;
    repeat (20) @(negedge sys_clk);
    chk(intReq_r, 1'b0);
    pullLow = 4'h0;
    wr(4'hA, 8'h00);
    wr(4'hC, 8'h0B);
    @(negedge sys_clk);
    pullLow = 4'h2;
    @(negedge sys_clk);
    pullLow = 4'h0;
    wr(4'hC, 8'h00);
    rdchk(4'hA, 8'hFF);
    wr(4'hE, 8'h02);
    standby(6'h04, 4'h4, nh);
    standby(6'h08, 4'h8, ns);
    chk(12'(ns > nh && ns < 300), 12'h001);
    rdchk(4'hE, 8'h02);
    @(negedge sys_clk);
    rstReq = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk(cpuReset_r, 1'b1);
    rstReq = 1'b0;
    waitRun();
    chk(invertedOutputPort_r, 4'hF);
    rdchk(4'hE, 8'h00);
    results();
  end
endmodule // reset_standby_interrupt_ctrl_bench

//--- tb/rsi_pins_model.sv
// Far-side pin model: reset pin, free-running oscillator and pulled-up wake pins.
`timescale 1ns/1ps
module rsi_pins_model (
  // Bench requests
  input logic sys_clk,
  input logic rstReq,
  input logic [3:0] pullLow,
  // Pins toward the block
  output logic resetPin_n,
  output logic oscillatorInput,
  output logic [3:0] pullupIn
);
  // The oscillator never stops, so the hold count always advances after release.
  initial oscillatorInput = 1'b0;
  always @(negedge sys_clk) oscillatorInput <= ~oscillatorInput;
  // Released pins rest at the pull-up level.
  assign pullupIn = ~pullLow;
  assign resetPin_n = ~rstReq;
endmodule // rsi_pins_model
